//--- rtl/timer2_pkg.sv
package timer2_pkg;
  // Byte addresses are four times the printed register index
  localparam logic [7:0] CMP_IDX   = 8'h23;
  localparam logic [7:0] CNT_IDX   = 8'h24;
  localparam logic [7:0] CTRL_IDX  = 8'h25;
  localparam logic [7:0] FLAG_IDX  = 8'h38;
  localparam logic [7:0] MASK_IDX  = 8'h39;
  localparam logic [9:0] CMP_ADDR  = {CMP_IDX, 2'b00};
  localparam logic [9:0] CNT_ADDR  = {CNT_IDX, 2'b00};
  localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [9:0] FLAG_ADDR = {FLAG_IDX, 2'b00};
  localparam logic [9:0] MASK_ADDR = {MASK_IDX, 2'b00};

  // Reset values
  localparam logic [7:0] CNT_RST   = 8'h00;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] CMP_RST   = 8'h00;
  localparam logic [1:0] FLAG_RST  = 2'h0;

  // Counter limits
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_TOP    = 8'hff;

  // Prescaler taps, as divisor minus one
  localparam int         PRE_W     = 10;
  localparam logic [9:0] DIV8_M1    = 10'h007;
  localparam logic [9:0] DIV32_M1   = 10'h01f;
  localparam logic [9:0] DIV64_M1   = 10'h03f;
  localparam logic [9:0] DIV128_M1  = 10'h07f;
  localparam logic [9:0] DIV256_M1  = 10'h0ff;
  localparam logic [9:0] DIV1024_M1 = 10'h3ff;

  // Compare output modes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // Control register layout
  typedef struct packed {
    logic       reserved;
    logic       pwmModeEnable;
    logic [1:0] compareOutputMode;
    logic       clearOnMatch;
    logic [2:0] clockSelect;
  } ctrl_t;

  // Interrupt flag and mask layout
  typedef struct packed {
    logic compareMatch;
    logic overflow;
  } irq_t;

  typedef enum logic {DIR_UP, DIR_DOWN} dir_t;
endpackage

//--- rtl/timer2_compare_counter.sv
// Notes on behaviour
// - 8-bit counter, undivided or prescaled clock
// - Select 0 stops; 1 direct; 2-7 divide
// - Control bit 7 always reads zero
// - Control bit 6 selects PWM mode
// - Normal mode match: none, toggle, clear, set
// - Clear-on-match zeroes counter next cycle
// - Without clear-on-match matches leave counter alone
// - Prescaled clear shows match one cycle
// - PWM mode ignores clear-on-match
// - Count writable; counting resumes next tick
// - Up in normal, up-down in PWM
// - Overflow and match flags, masked interrupts
// - Port data write never presets output
// - PWM gives centred glitch-free 8-bit output
// - Match only by counting; flag next cycle
// - PWM runs 0 to 255 to 0
// - PWM modes 10/11 set and clear by direction
// - PWM compare buffered until top; reads buffer
module timer2_compare_counter
  import timer2_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             irq,
  output logic             compareOutputPin,
  output logic             compareOutputActive
);

  ctrl_t           ctrl_r;
  irq_t            flags_r;
  irq_t            mask_r;
  dir_t            dir_r;
  logic [7:0]      cnt_r;
  logic [7:0]      cnt_nxt;
  logic [7:0]      cmpBuf_r;
  logic [7:0]      cmpAct_r;
  logic [PRE_W-1:0] pre_r;
  logic            ack_r;
  logic            justCounted_r;
  logic            ocOut_r;
  logic [31:0]     readdata_r;
  logic            req;
  logic            accept;
  logic            lane0;
  logic            wrCount;
  logic            wrCmp;
  logic            wrCtrl;
  logic            wrFlag;
  logic            wrMask;
  logic            tick;
  logic            matchEv;
  logic            ovfEv;
  logic            ctcClear;
  logic [7:0]      readMux;

  // Prescaler tap decode for the selected division
  function automatic logic tickSel(input logic [2:0] cs, input logic [PRE_W-1:0] pre);
    logic r;
    r = 1'b0;
    case (cs)
      3'h0:    r = 1'b0;
      3'h1:    r = 1'b1;
      3'h2:    r = ((pre & DIV8_M1) == DIV8_M1);
      3'h3:    r = ((pre & DIV32_M1) == DIV32_M1);
      3'h4:    r = ((pre & DIV64_M1) == DIV64_M1);
      3'h5:    r = ((pre & DIV128_M1) == DIV128_M1);
      3'h6:    r = ((pre & DIV256_M1) == DIV256_M1);
      3'h7:    r = ((pre & DIV1024_M1) == DIV1024_M1);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Address decode: one wait cycle, then the access completes
  assign req         = read | write;
  assign waitrequest = req & ~ack_r;
  assign accept      = req & ack_r;
  assign lane0       = byteenable[0];
  assign wrCount     = accept & write & lane0 & (address == CNT_ADDR);
  assign wrCmp       = accept & write & lane0 & (address == CMP_ADDR);
  assign wrCtrl      = accept & write & lane0 & (address == CTRL_ADDR);
  assign wrFlag      = accept & write & lane0 & (address == FLAG_ADDR);
  assign wrMask      = accept & write & lane0 & (address == MASK_ADDR);
  assign readdata    = readdata_r;

  // Wait-state generator
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    readMux = 8'h00;
    case (address)
      CNT_ADDR:  readMux = cnt_r;
      CMP_ADDR:  readMux = cmpBuf_r;
      CTRL_ADDR: readMux = {1'b0, ctrl_r[6:0]};
      FLAG_ADDR: readMux = {6'h00, flags_r};
      MASK_ADDR: readMux = {6'h00, mask_r};
      default:   readMux = 8'h00;
    endcase
  end

  // Read data captured during the wait cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata_r <= 32'h0000_0000;
    end else if (read & ~ack_r) begin
      readdata_r <= {24'h00_0000, readMux};
    end
  end

  // Control register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_r <= {1'b0, writedata[6:0]};
    end
  end

  // Free-running prescaler on the source clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 10'h001;
    end
  end

  assign tick = tickSel(ctrl_r.clockSelect, pre_r);

  // Match only when the counter itself stepped onto the compare value
  assign matchEv  = justCounted_r & (cnt_r == cmpAct_r);
  assign ctcClear = matchEv & ctrl_r.clearOnMatch & ~ctrl_r.pwmModeEnable;
  // In PWM the count only ever leaves zero upward, whatever the direction flag says
  assign ovfEv    = tick & (ctrl_r.pwmModeEnable ? (cnt_r == CNT_BOTTOM)
                                                 : (cnt_r == CNT_TOP));

  // Next count value: up only, or up then down
  always_comb begin
    cnt_nxt = cnt_r;
    if (!ctrl_r.pwmModeEnable) begin
      cnt_nxt = cnt_r + 8'h01;
    end else if (dir_r == DIR_UP) begin
      cnt_nxt = (cnt_r == CNT_TOP) ? cnt_r - 8'h01 : cnt_r + 8'h01;
    end else begin
      cnt_nxt = (cnt_r == CNT_BOTTOM) ? cnt_r + 8'h01 : cnt_r - 8'h01;
    end
  end

  // Counter: software write first, then match clear, then tick
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= CNT_RST;
    end else if (wrCount) begin
      cnt_r <= writedata[7:0];
    end else if (ctcClear) begin
      cnt_r <= CNT_BOTTOM;
    end else if (tick) begin
      cnt_r <= cnt_nxt;
    end
  end

  // Marks a cycle whose count came from counting, not from a write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      justCounted_r <= 1'b0;
    end else begin
      justCounted_r <= tick & ~wrCount & ~ctcClear;
    end
  end

  // Count direction in PWM mode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_r <= DIR_UP;
    end else if (!ctrl_r.pwmModeEnable) begin
      dir_r <= DIR_UP;
    end else if (tick && cnt_r == CNT_TOP) begin
      dir_r <= DIR_DOWN;
    end else if (tick && cnt_r == CNT_BOTTOM) begin
      dir_r <= DIR_UP;
    end
  end

  // Compare buffer; software always reads the latest write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmpBuf_r <= CMP_RST;
    end else if (wrCmp) begin
      cmpBuf_r <= writedata[7:0];
    end
  end

  // Active compare value; in PWM latched only at the top
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmpAct_r <= CMP_RST;
    end else if (!ctrl_r.pwmModeEnable) begin
      cmpAct_r <= wrCmp ? writedata[7:0] : cmpBuf_r;
    end else if (cnt_r == CNT_TOP) begin
      cmpAct_r <= cmpBuf_r;
    end
  end

  // Compare output; driven by matches, or in PWM by a compare of 0 or 255, never by port data
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ocOut_r <= 1'b0;
    end else if (!ctrl_r.pwmModeEnable) begin
      if (matchEv) begin
        case (ctrl_r.compareOutputMode)
          COM_TOGGLE: ocOut_r <= ~ocOut_r;
          COM_CLEAR:  ocOut_r <= 1'b0;
          COM_SET:    ocOut_r <= 1'b1;
          default:    ocOut_r <= ocOut_r;
        endcase
      end
    end else if (ctrl_r.compareOutputMode[1]) begin
      if (cmpAct_r == CNT_BOTTOM) begin
        ocOut_r <= ctrl_r.compareOutputMode[0];
      end else if (cmpAct_r == CNT_TOP) begin
        ocOut_r <= ~ctrl_r.compareOutputMode[0];
      end else if (matchEv) begin
        ocOut_r <= (dir_r == DIR_DOWN) ^ ctrl_r.compareOutputMode[0];
      end
    end
  end

  // Pin connection: port logic keeps the pin unless a mode claims it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      compareOutputActive <= 1'b0;
    end else if (ctrl_r.pwmModeEnable) begin
      compareOutputActive <= ctrl_r.compareOutputMode[1];
    end else begin
      compareOutputActive <= (ctrl_r.compareOutputMode != COM_OFF);
    end
  end

  assign compareOutputPin = ocOut_r;

  // Sticky flags; a new event wins over a write-one clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r <= FLAG_RST;
    end else begin
      flags_r.overflow     <= ovfEv |
                              (flags_r.overflow & ~(wrFlag & writedata[0]));
      flags_r.compareMatch <= matchEv |
                              (flags_r.compareMatch & ~(wrFlag & writedata[1]));
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_r <= FLAG_RST;
    end else if (wrMask) begin
      mask_r <= writedata[1:0];
    end
  end

  assign irq = |(flags_r & mask_r);

  // Step sequences shared by the checks
  sequence seqMatch;
    matchEv && !wrCount;
  endsequence

  sequence seqClearHeld;
    (cnt_r == CNT_BOTTOM) ##1 (cnt_r == CNT_BOTTOM || justCounted_r || $past(wrCount));
  endsequence

  AST_CTC_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seqMatch and (ctrl_r.clearOnMatch && !ctrl_r.pwmModeEnable) |=> seqClearHeld)
    else $error("counter not cleared after match");

  AST_MATCH_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_b)
    matchEv |=> flags_r.compareMatch)
    else $error("match flag not set in next cycle");

  AST_WRITE_NO_MATCH: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrCount |=> !matchEv)
    else $error("count write caused a match");

  AST_STOPPED: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ctrl_r.clockSelect == 3'h0 && !wrCount && !ctcClear) |=> $stable(cnt_r))
    else $error("stopped counter moved");

  AST_CTRL_RSV: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (read && !ack_r && address == CTRL_ADDR) |=> (readdata[7] == 1'b0) && !waitrequest)
    else $error("reserved control bit read nonzero");

  AST_UP_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tick && !ctrl_r.pwmModeEnable && !wrCount && !ctcClear) |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("normal mode did not count up");

  AST_PWM_TURN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tick && ctrl_r.pwmModeEnable && cnt_r == CNT_TOP && !wrCount) |=>
      (dir_r == DIR_DOWN) && (cnt_r == 8'hfe))
    else $error("PWM counter did not turn at top");

  AST_PWM_BUFFER: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ctrl_r.pwmModeEnable && $past(ctrl_r.pwmModeEnable) && cnt_r != CNT_TOP && !wrCtrl)
      |=> $stable(cmpAct_r))
    else $error("PWM compare changed away from top");

  AST_TOGGLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    seqMatch and (!ctrl_r.pwmModeEnable && ctrl_r.compareOutputMode == COM_TOGGLE && !wrCtrl)
      |=> ocOut_r != $past(ocOut_r))
    else $error("output did not toggle on match");

  AST_PWM_NO_CTC: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (matchEv && ctrl_r.pwmModeEnable && !wrCount && cnt_r > 8'h01)
      |=> cnt_r != CNT_BOTTOM)
    else $error("PWM mode cleared counter on match");

  // Overflow, flag clearing, counting, PWM output, bus timing and prescaler gap
  AST_PWM_OVF: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tick && ctrl_r.pwmModeEnable && cnt_r == CNT_BOTTOM) |=> flags_r.overflow)
    else $error("PWM overflow flag not set leaving bottom");

  AST_NORMAL_OVF: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tick && !ctrl_r.pwmModeEnable && cnt_r == CNT_TOP) |=> flags_r.overflow)
    else $error("overflow flag not set at wrap");

  AST_FLAG_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wrFlag && writedata[0] && !ovfEv) |=> !flags_r.overflow)
    else $error("overflow flag not cleared by write of one");

  AST_CTC_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (seqMatch and (!ctrl_r.clearOnMatch && !ctrl_r.pwmModeEnable && tick))
      |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("match disturbed counter without clear-on-match");

  AST_PWM_LOW: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ctrl_r.pwmModeEnable && ctrl_r.compareOutputMode == COM_CLEAR && cmpAct_r == CNT_BOTTOM)
      |=> !ocOut_r)
    else $error("PWM output not held low at compare zero");

  AST_PWM_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ctrl_r.pwmModeEnable && ctrl_r.compareOutputMode == COM_SET && cmpAct_r == CNT_BOTTOM)
      |=> ocOut_r)
    else $error("inverted PWM output not held high at compare zero");

  AST_PWM_FULL: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ctrl_r.pwmModeEnable && ctrl_r.compareOutputMode == COM_CLEAR && cmpAct_r == CNT_TOP)
      |=> ocOut_r)
    else $error("PWM output not held high at compare top");

  AST_ONE_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req && waitrequest) |=> (!waitrequest || !req))
    else $error("bus access took more than one wait cycle");

  AST_DIV8_GAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tick && ctrl_r.clockSelect == 3'h2 && !wrCtrl) |=> !tick)
    else $error("divide-by-8 ticks in adjacent cycles");

  AST_PWM_BOTTOM: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tick && ctrl_r.pwmModeEnable && cnt_r == CNT_BOTTOM && !wrCount && !wrCtrl) |=>
      (dir_r == DIR_UP) && (cnt_r == 8'h01))
    else $error("PWM counter did not turn at bottom");

endmodule

//--- verification/test_timer2_compare_counter.sv
`define CHECK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end

module test_timer2_compare_counter
  import timer2_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [9:0]  address = 10'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  byteenable = 4'hf;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  logic        compareOutputPin;
  logic        compareOutputActive;
  logic [7:0]  rdVal;
  logic        pinBefore;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cycleCnt = 0;
  int          divs[7] = '{1, 8, 32, 64, 128, 256, 1024};

  timer2_compare_counter i_dut (
    .ref_clk            (ref_clk),
    .rst_b              (rst_b),
    .address            (address),
    .read               (read),
    .write              (write),
    .byteenable         (byteenable),
    .writedata          (writedata),
    .readdata           (readdata),
    .waitrequest        (waitrequest),
    .irq                (irq),
    .compareOutputPin   (compareOutputPin),
    .compareOutputActive(compareOutputActive)
  );

  // Clock, 8 ns period
  always #4 ref_clk = ~ref_clk;

  // Cuts a hang short
  always @(posedge ref_clk) begin
    cycleCnt++;
    if (cycleCnt == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  // Counts and verdict
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  // Bus write, held until waitrequest is sampled low
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] be = 4'hf);
    @(posedge ref_clk);
    address    <= a;
    writedata  <= {24'h0, d};
    byteenable <= be;
    write      <= 1'b1;
    @(posedge ref_clk);
    while (waitrequest) @(posedge ref_clk);
    write <= 1'b0;
  endtask

  // Bus read, data taken at the completing edge
  task automatic rd(input logic [9:0] a);
    @(posedge ref_clk);
    address <= a;
    read    <= 1'b1;
    @(posedge ref_clk);
    while (waitrequest) @(posedge ref_clk);
    rdVal = readdata[7:0];
    read <= 1'b0;
  endtask

  task automatic chk(input logic [9:0] a, input logic [7:0] e, input string nm);
    rd(a);
    `CHECK(nm, e, rdVal)
  endtask

  // Counts high cycles of the pin over one PWM period, clear-on-match also set
  task automatic pwmDuty(input logic [1:0] md, input logic [7:0] cmp, input int lo, input int hi);
    int highCnt = 0;
    wr(CMP_ADDR, cmp);
    wr(CTRL_ADDR, {2'b01, md, 4'b1001});
    waitCyc(1100);
    repeat (510) begin
      @(posedge ref_clk);
      if (compareOutputPin === 1'b1) highCnt++;
    end
    `CHECK("pwm high time", 1'h1, highCnt >= lo && highCnt <= hi)
    `CHECK("pwm pin owned", md[1], compareOutputActive)
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Reset values, unmapped read, reserved bit
    chk(CNT_ADDR, CNT_RST, "count");
    chk(CTRL_ADDR, CTRL_RST, "control");
    chk(CMP_ADDR, CMP_RST, "compare");
    chk(FLAG_ADDR, {6'h0, FLAG_RST}, "flags");
    chk(MASK_ADDR, 8'h00, "mask");
    chk(10'h000, 8'h00, "unmapped");
    wr(CTRL_ADDR, 8'h80);
    chk(CTRL_ADDR, 8'h00, "reserved bit");
    done("reset");
    // Stopped timer, equal writes, disabled byte lane
    wr(CMP_ADDR, 8'h33);
    wr(FLAG_ADDR, 8'h03);
    wr(CNT_ADDR, 8'h33);
    wr(CNT_ADDR, 8'h77, 4'he);
    waitCyc(20);
    chk(CNT_ADDR, 8'h33, "held count");
    chk(FLAG_ADDR, 8'h00, "no write match");
    done("stopped");
    // Clock selects 1 to 7 each give 7 to 12 ticks in eight divided periods plus bus overhead
    for (int i = 0; i < 7; i++) begin
      wr(CNT_ADDR, 8'h00);
      wr(CTRL_ADDR, 8'(i + 1));
      waitCyc(8 * divs[i]);
      wr(CTRL_ADDR, 8'h00);
      rd(CNT_ADDR);
      `CHECK("tick count", 1'h1, rdVal >= 8'h07 && rdVal <= 8'h0c)
    end
    done("prescaler");
    // Overflow past a match, flags cleared by ones, per-bit mask
    wr(CNT_ADDR, 8'hf0);
    wr(CMP_ADDR, 8'h10);
    wr(FLAG_ADDR, 8'h03);
    wr(MASK_ADDR, 8'h01);
    waitCyc(1);
    `CHECK("irq idle", 1'h0, irq)
    wr(CTRL_ADDR, 8'h01);
    waitCyc(40);
    wr(CTRL_ADDR, 8'h00);
    rd(CNT_ADDR);
    `CHECK("free count", 1'h1, rdVal > 8'h10 && rdVal < 8'h40)
    chk(FLAG_ADDR, 8'h03, "both flags");
    `CHECK("irq overflow", 1'h1, irq)
    wr(FLAG_ADDR, 8'h01);
    waitCyc(1);
    `CHECK("irq masked", 1'h0, irq)
    wr(MASK_ADDR, 8'h02);
    waitCyc(1);
    `CHECK("irq compare", 1'h1, irq)
    wr(FLAG_ADDR, 8'h02);
    chk(FLAG_ADDR, 8'h00, "flags cleared");
    done("interrupts");
    // Set and clear actions with clear-on-match on a divided clock
    wr(CNT_ADDR, 8'h00);
    wr(CMP_ADDR, 8'h04);
    wr(CTRL_ADDR, 8'h3a);
    waitCyc(100);
    `CHECK("pin set", 1'h1, compareOutputPin)
    `CHECK("pin owned", 1'h1, compareOutputActive)
    repeat (4) begin
      rd(CNT_ADDR);
      `CHECK("cleared count", 1'h1, rdVal <= 8'h04)
    end
    wr(CTRL_ADDR, 8'h2a);
    waitCyc(100);
    `CHECK("pin clear", 1'h0, compareOutputPin)
    // One match toggles the pin once
    wr(CTRL_ADDR, 8'h10);
    wr(CNT_ADDR, 8'h0f);
    wr(CMP_ADDR, 8'h10);
    pinBefore = compareOutputPin;
    wr(CTRL_ADDR, 8'h11);
    waitCyc(20);
    wr(CTRL_ADDR, 8'h00);
    // Pin ownership is a register: it drops one edge after the control write
    waitCyc(2);
    `CHECK("pin toggle", ~pinBefore, compareOutputPin)
    `CHECK("pin released", 1'h0, compareOutputActive)
    done("normal output");
    // Centred PWM in modes 10 and 11, unowned pin in 01, flags and buffered compare
    wr(FLAG_ADDR, 8'h03);
    pwmDuty(2'h2, 8'h80, 250, 262);
    chk(FLAG_ADDR, 8'h03, "pwm flags");
    pwmDuty(2'h3, 8'h80, 248, 260);
    pwmDuty(2'h2, 8'h00, 0, 0);
    pwmDuty(2'h3, 8'h00, 510, 510);
    pwmDuty(2'h2, 8'hff, 510, 510);
    pwmDuty(2'h1, 8'h80, 0, 510);
    chk(CTRL_ADDR, 8'h59, "pwm control");
    wr(CMP_ADDR, 8'h40);
    chk(CMP_ADDR, 8'h40, "buffered compare");
    done("pwm");
    conclude();
  end
endmodule
